// file: rtl/atu_pkg.sv
// address translation unit constants, encodings and carrier types
package atu_pkg;
  localparam int HASH_W = 4;
  localparam int NUM_SETS = 16;
  localparam int NUM_WAYS = 4;
  localparam int ENTRY_W = 44;
  localparam int BN_W = 32;
  localparam int SEG_W = 12;
  localparam int RING_W = 4;
  localparam int MASK_W = 7;
  // page size mask covers byte_number bits 15:9 (doc bits 48..54)
  localparam int MASK_LSB = 9;
  localparam logic [15:0] MASK_HIGH_ONES = 16'hffff;
  localparam logic [8:0] MASK_LOW_ZEROS = 9'h000;
  localparam logic [3:0] MIN_OFFSET_BITS = 4'h9;
  // function lengths in clocks, without memory conflicts
  localparam int PURGE_CYCLES = 17;
  localparam int SHORT_CYCLES = 2;
  localparam logic [3:0] PURGE_LAST = 4'(NUM_SETS - 1);
  localparam logic [2:0] LOCK_TIMEOUT_CLK = 3'h6;
  // validity word field positions (low bit of each field)
  localparam int KEY_LSB = 22;
  localparam int LOCK_LSB = 16;
  localparam int XP_LSB = 12;
  localparam int RP_LSB = 10;
  localparam int WP_LSB = 8;
  localparam int R1_LSB = 4;
  localparam int R2_LSB = 0;
  // associative entry control bits
  localparam int CTL_MON = 2;
  localparam int CTL_JOB = 1;
  localparam int CTL_MOD = 0;

  typedef enum logic [3:0] {
    F_XLATE = 4'h0,
    F_XLATE_WR = 4'h1,
    F_REAL = 4'h2,
    F_LD_PSM = 4'h3,
    F_LD_ASSOC = 4'h4,
    F_LD_REAL = 4'h5,
    F_LD_VALID = 4'h6,
    F_PURGE_ALL = 4'h7,
    F_PURGE_PVA = 4'ha
  } atu_func_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_XLATE = 2'h1,
    S_PURGE = 2'h2,
    S_DONE = 2'h3
  } atu_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_UTP = 3'h1,
    SEL_RMA = 3'h2,
    SEL_PSM = 3'h3,
    SEL_ASSOC = 3'h4,
    SEL_REAL = 3'h5,
    SEL_VALID = 3'h6
  } atu_sense_t;

  typedef struct packed {
    atu_func_t func;
    logic [RING_W-1:0] ring;
    logic [SEG_W-1:0] space_index;
    logic [BN_W-1:0] bn;
    logic [MASK_W-1:0] mask_copy;
    logic [BN_W-1:0] data;
  } atu_req_t;
endpackage

// file: rtl/atu_top.sv
// address translation unit: masked hash lookup, locking, sense mux
// Functional notes
// - seven-bit page mask over byte bits 48..54
// - mask ones count selects 512B..64KB page
// - offset = bn OR mask; page = bn OR NOT mask
// - hit compare; real AND masked offset
// - files: 16 sets, 4 ways; 44-bit assoc, 32-bit real and validity entries
// - hash = segment XOR page bits; compare ways
// - compare gated by full, modified, parity
// - real address strobed only at completion
// - single hit reads files; multiple flags error
// - entries loaded by microcode; purge/write clears
// - assoc/real parity error blocks hit, logs
// - validity parity checked after hold, fatal
// - pointer captures input address at every completion
// - miss/validity fault locks address, pointer
// - sense mux reads files; default program address; while locked the code forces the pointer (utp_o) for every select
// - execution request wins simultaneous arrival
// - full while busy: purge 17, others 2
// - write waits for data; kill or clear
// - port busy holds address and completion
// - six-clock timeout; exec request then unlocks
// - input register muxed from exec or fetch
`timescale 1ns/1ps
module atu_top (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic kill_i,
  input wire logic exec_req_i,
  input wire atu_pkg::atu_req_t exec_in_i,
  input wire logic ifu_req_i,
  input wire atu_pkg::atu_req_t ifu_in_i,
  input wire logic wdata_valid_i,
  input wire logic port_busy_i,
  input wire logic monitor_mode_i,
  input wire atu_pkg::atu_sense_t sense_sel_i,
  input wire logic [5:0] sense_idx_i,
  input wire logic [63:0] prog_addr_i,
  output logic exec_ack_o,
  output logic ifu_ack_o,
  output logic busy_o,
  output logic done_o,
  output logic rma_full_o,
  output logic [31:0] rma_o,
  output logic [47:0] utp_o,
  output logic locked_o,
  output logic miss_o,
  output logic val_fault_o,
  output logic multi_hit_o,
  output logic corr_err_o,
  output logic val_par_err_o,
  output logic [63:0] sense_o
);
  import atu_pkg::*;
  default clocking cb @(posedge mclk_i); // shared by every assertion
  endclocking
  default disable iff (sys_rst_i);
  // the three files, with parity and control beside them
  logic [ENTRY_W-1:0] a_key [NUM_SETS][NUM_WAYS];
  logic [2:0] a_ctl [NUM_SETS][NUM_WAYS];
  logic a_par [NUM_SETS][NUM_WAYS];
  logic [BN_W-1:0] r_dat [NUM_SETS][NUM_WAYS];
  logic r_par [NUM_SETS][NUM_WAYS];
  logic [BN_W-1:0] v_dat [NUM_SETS][NUM_WAYS];
  logic v_par [NUM_SETS][NUM_WAYS];
  logic [1:0] lru [NUM_SETS];
  atu_state_t st, next_st;
  atu_req_t cur, next_cur;
  logic [MASK_W-1:0] page_size_mask_reg, next_psm;
  logic [3:0] cnt, next_cnt;
  logic [2:0] tmr, next_tmr;
  logic hit_q, next_hit_q, wseen, next_wseen;
  logic [BN_W-1:0] hold_rma, next_hold_rma, hold_v, next_hold_v, next_rma;
  logic hold_vp, next_hold_vp, ld_hold, next_ld_hold;
  logic [HASH_W-1:0] ld_addr, next_ld_addr, hash, set;
  logic [1:0] ld_way, next_ld_way, perm;
  logic next_exec_ack, next_ifu_ack, next_done, next_rma_full;
  logic next_locked, next_miss, next_vfault, next_multi, next_corr;
  logic next_vperr;
  logic [47:0] next_utp;
  logic [63:0] next_sense;
  // sense index split into set and way
  logic [3:0] sx_s;
  logic [1:0] sx_w;
  assign {sx_s, sx_w} = sense_idx_i;
  // mask expansion and masked address forms
  logic [BN_W-1:0] full_mask, moff, mpn;
  // five bits: an all-zero mask gives sixteen offset bits
  logic [4:0] off_bits;
  logic [NUM_WAYS-1:0] match, hit, perr, clr;
  always_comb begin
    full_mask = {MASK_HIGH_ONES, page_size_mask_reg, MASK_LOW_ZEROS};
    moff = cur.bn | full_mask;
    mpn = cur.bn | ~full_mask;
    off_bits = 5'(MIN_OFFSET_BITS);
    // zeros in the mask copy widen the offset, shifting hash bits up
    for (int i = 0; i < MASK_W; i++) begin
      if (!cur.mask_copy[i]) begin
        off_bits = off_bits + 5'h1;
      end
    end
    hash = cur.space_index[3:0] ^ 4'(cur.bn >> off_bits);
    set = ld_hold ? ld_addr : hash;
  end
  // per-way compare, all four ways of the set in parallel
  genvar w;
  generate
    for (w = 0; w < NUM_WAYS; w++) begin : g_way
      logic ok, aerr, rerr;
      always_comb begin
        ok = (monitor_mode_i ? a_ctl[set][w][CTL_MON]
                             : a_ctl[set][w][CTL_JOB])
             & a_ctl[set][w][CTL_MOD];
        aerr = (^a_key[set][w]) != a_par[set][w];
        rerr = (^r_dat[set][w]) != r_par[set][w];
        match[w] = a_key[set][w] == {cur.space_index, mpn};
        hit[w] = match[w] & ok & ~aerr & ~rerr;
        perr[w] = match[w] & ok & (aerr | rerr);
        // write requests drop unmodified copies of the page
        clr[w] = match[w] & ((cur.func == F_PURGE_PVA)
                 | ((cur.func == F_XLATE_WR) & ~a_ctl[set][w][CTL_MOD]));
      end
    end
  endgenerate
  // validity check on the holding register
  logic vperr, vbad, is_wr, is_xl, acc_x, acc_i, complete;
  always_comb begin
    is_wr = cur.func == F_XLATE_WR;
    is_xl = (cur.func == F_XLATE) | is_wr;
    vperr = (^hold_v) != hold_vp;
    perm = is_wr ? hold_v[WP_LSB+:2] : hold_v[RP_LSB+:2];
    vbad = vperr | (perm == 2'h0)
           | (cur.ring < hold_v[R1_LSB+:4]) | (cur.ring > hold_v[R2_LSB+:4]);
    // completion waits on storage and on write data
    complete = (st == S_DONE) & ~port_busy_i
               & (~is_wr | wseen) & ~kill_i;
    acc_x = (st == S_IDLE) & exec_req_i
            & (~locked_o | (tmr == 3'h0));
    acc_i = (st == S_IDLE) & ifu_req_i & ~exec_req_i
            & ~locked_o;
  end
  // sequencer, lock and output next values
  always_comb begin
    next_st = st;
    {next_cur, next_psm, next_cnt} = {cur, page_size_mask_reg, cnt};
    next_tmr = (tmr != 3'h0) ? tmr - 3'h1 : tmr;
    {next_hit_q, next_hold_vp, next_ld_hold} = {hit_q, hold_vp, ld_hold};
    {next_hold_rma, next_hold_v} = {hold_rma, hold_v};
    {next_ld_addr, next_ld_way} = {ld_addr, ld_way};
    next_wseen = (st != S_IDLE) & (wseen | wdata_valid_i) & ~complete;
    {next_exec_ack, next_ifu_ack, next_done} = {acc_x, acc_i, complete};
    {next_rma, next_utp, next_locked} = {rma_o, utp_o, locked_o};
    next_rma_full = rma_full_o & port_busy_i;
    {next_miss, next_vfault, next_multi, next_corr, next_vperr} = 5'h00;
    case (st)
      S_IDLE: begin
        if (acc_x | acc_i) begin
          next_cur = acc_x ? exec_in_i : ifu_in_i;
          next_wseen = wdata_valid_i;
          next_cnt = 4'h0;
          next_st = ((acc_x ? exec_in_i.func : ifu_in_i.func) == F_PURGE_ALL)
                    ? S_PURGE : S_XLATE;
          if (acc_x) begin
            next_locked = 1'b0;
          end
        end
      end
      S_XLATE: begin
        next_hit_q = |hit;
        next_multi = is_xl & ($countones(hit) > 1);
        next_corr = |perr;
        next_hold_rma = '0;
        next_hold_v = '0;
        next_hold_vp = 1'b0;
        for (int i = 0; i < NUM_WAYS; i++) begin
          if (hit[i]) begin
            next_hold_rma = r_dat[set][i] & moff;
            next_hold_v = v_dat[set][i];
            next_hold_vp = v_par[set][i];
          end
        end
        if (cur.func == F_LD_ASSOC) begin
          next_ld_hold = 1'b1;
          next_ld_addr = hash;
          next_ld_way = lru[hash];
        end
        if (cur.func == F_LD_VALID) begin
          next_ld_hold = 1'b0;
        end
        if (cur.func == F_LD_PSM) begin
          next_psm = cur.data[MASK_LSB+:MASK_W];
        end
        next_st = S_DONE;
      end
      S_PURGE: begin
        next_cnt = cnt + 4'h1;
        if (cnt == PURGE_LAST) begin
          next_st = S_DONE;
        end
      end
      S_DONE: begin
        if (complete) begin
          next_st = S_IDLE;
          next_utp = {cur.ring, cur.space_index, cur.bn};
          if (is_xl & (~hit_q | vbad)) begin
            next_locked = 1'b1;
            next_tmr = LOCK_TIMEOUT_CLK;
            next_miss = ~hit_q;
            next_vfault = hit_q & vbad;
            next_vperr = hit_q & vperr;
          end else if (is_xl) begin
            next_rma = hold_rma;
            next_rma_full = 1'b1;
          end else if (cur.func == F_REAL) begin
            next_rma = cur.bn;
            next_rma_full = 1'b1;
          end
        end
      end
      default: next_st = S_IDLE;
    endcase
    if (kill_i) begin
      next_st = S_IDLE;
    end
    // sense mux; a lock forces the pointer for convenience
    case (sense_sel_i)
      SEL_UTP: next_sense = {16'h0000, utp_o};
      SEL_RMA: next_sense = {32'h0000_0000, rma_o};
      SEL_PSM: next_sense = {57'h0, page_size_mask_reg};
      SEL_ASSOC: next_sense = {17'h0, a_ctl[sx_s][sx_w], a_key[sx_s][sx_w]};
      SEL_REAL: next_sense = {32'h0, r_dat[sx_s][sx_w]};
      SEL_VALID: next_sense = {32'h0, v_dat[sx_s][sx_w]};
      default: next_sense = prog_addr_i;
    endcase
    if (locked_o) begin
      next_sense = {16'h0000, utp_o};
    end
  end
  // state registers; master clear empties and unlocks
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= S_IDLE;
      {cur, page_size_mask_reg, cnt, tmr} <= '0;
      {hit_q, wseen, hold_vp, ld_hold, hold_rma, hold_v, ld_addr, ld_way} <= '0;
      {exec_ack_o, ifu_ack_o, busy_o, done_o, rma_full_o} <= '0;
      {locked_o, miss_o, val_fault_o, multi_hit_o} <= '0;
      {corr_err_o, val_par_err_o, rma_o, utp_o, sense_o} <= '0;
    end else begin
      st <= next_st;
      {cur, page_size_mask_reg, cnt, tmr} <= {next_cur, next_psm, next_cnt, next_tmr};
      {hit_q, wseen, hold_vp, ld_hold} <=
        {next_hit_q, next_wseen, next_hold_vp, next_ld_hold};
      {hold_rma, hold_v} <= {next_hold_rma, next_hold_v};
      {ld_addr, ld_way} <= {next_ld_addr, next_ld_way};
      {exec_ack_o, ifu_ack_o} <= {next_exec_ack, next_ifu_ack};
      busy_o <= next_st != S_IDLE;
      done_o <= next_done;
      rma_full_o <= next_rma_full;
      {locked_o, miss_o, val_fault_o, multi_hit_o} <=
        {next_locked, next_miss, next_vfault, next_multi};
      {corr_err_o, val_par_err_o} <= {next_corr, next_vperr};
      {rma_o, utp_o, sense_o} <= {next_rma, next_utp, next_sense};
    end
  end
  // file writes: loads, purges and write-request clears
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        lru[s] <= 2'h0;
        for (int k = 0; k < NUM_WAYS; k++) begin
          a_ctl[s][k] <= 3'h0;
        end
      end
    end else if (st == S_PURGE) begin
      for (int k = 0; k < NUM_WAYS; k++) begin
        a_ctl[cnt][k] <= 3'h0;
      end
    end else if (st == S_XLATE) begin
      for (int k = 0; k < NUM_WAYS; k++) begin
        if (clr[k]) begin
          a_ctl[set][k] <= 3'h0;
        end
      end
      case (cur.func)
        F_LD_ASSOC: begin
          a_key[hash][lru[hash]] <= {cur.space_index, cur.bn};
          a_par[hash][lru[hash]] <= ^{cur.space_index, cur.bn};
          a_ctl[hash][lru[hash]] <= cur.data[2:0];
        end
        F_LD_REAL: begin
          r_dat[ld_addr][ld_way] <= cur.data;
          r_par[ld_addr][ld_way] <= ^cur.data;
        end
        F_LD_VALID: begin
          v_dat[ld_addr][ld_way] <= cur.data;
          v_par[ld_addr][ld_way] <= ^cur.data;
          lru[ld_addr] <= ld_way + 2'h1;
        end
        default: ;
      endcase
    end
  end
  a_exec_first: assert property (
    (st == S_IDLE && exec_req_i && ifu_req_i && !locked_o && !kill_i)
    |=> exec_ack_o && !ifu_ack_o) else $error("fetch won over exec");
  a_lock_timeout: assert property (
    $rose(locked_o) |-> !exec_ack_o [*6]) else $error("unlock too early");
  a_busy_holds_rma: assert property (
    (port_busy_i && rma_full_o) |=> $stable(rma_o) && rma_full_o)
    else $error("address moved under port busy");
  a_short_length: assert property (
    disable iff (sys_rst_i || kill_i)
    ((exec_ack_o || ifu_ack_o) && cur.func != F_PURGE_ALL
     && cur.func != F_XLATE_WR) ##1 !port_busy_i |=> done_o && !busy_o)
    else $error("short function not two cycles");
  a_purge_length: assert property (
    disable iff (sys_rst_i || kill_i)
    ((exec_ack_o || ifu_ack_o) && cur.func == F_PURGE_ALL)
    |-> (busy_o && !done_o) [*8] ##8 (busy_o && !done_o))
    else $error("purge ended early");
  a_write_waits: assert property (
    (st == S_DONE && is_wr && !wseen && !wdata_valid_i) |=> !done_o)
    else $error("write finished without data");
  a_miss_locks: assert property (
    (miss_o || val_fault_o) |-> locked_o && $changed(locked_o))
    else $error("fault did not lock");
  a_utp_frozen: assert property (
    (locked_o ##1 locked_o) |-> $stable(utp_o))
    else $error("pointer moved while locked");
  a_sense_default: assert property (
    (sense_sel_i == SEL_NONE && !locked_o) |=> sense_o == $past(prog_addr_i))
    else $error("sense default wrong");
  a_clear_empties: assert property (disable iff (1'b0)
    sys_rst_i |=> !busy_o && !locked_o && !rma_full_o)
    else $error("master clear left state");
endmodule

// file: tb/atu_far_end.sv
// far-end model: storage input rank and exec-unit write data supply
`timescale 1ns/1ps
module atu_far_end (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic rma_full_i,
  input wire logic exec_ack_i,
  input wire atu_pkg::atu_func_t func_i,
  input wire logic [3:0] busy_len_i,
  input wire logic [3:0] wr_dly_i,
  output logic port_busy_o,
  output logic wdata_valid_o
);
  import atu_pkg::*;
  logic full_q;
  logic [3:0] busy_cnt;
  logic [3:0] wr_cnt;
  // rank takes each new address, then refuses for busy_len clocks
  always_ff @(posedge mclk_i) begin
    full_q <= rma_full_i;
    if (sys_rst_i) begin
      busy_cnt <= 4'h0;
      wr_cnt <= 4'h0;
    end else begin
      if (rma_full_i && !full_q && busy_cnt == 4'h0) begin
        busy_cnt <= busy_len_i;
      end else if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end
      // zero delay: data never comes, so the write hangs
      if (exec_ack_i && func_i == F_XLATE_WR) begin
        wr_cnt <= wr_dly_i;
      end else if (wr_cnt != 4'h0) begin
        wr_cnt <= wr_cnt - 4'h1;
      end
    end
  end
  assign port_busy_o = (busy_cnt != 4'h0);
  assign wdata_valid_o = (wr_cnt == 4'h1);
endmodule

// file: tb/atu_tb_top.sv
// self-checking bench for the address translation unit
`timescale 1ns/1ps
module atu_tb_top;
  import atu_pkg::*;
  typedef struct {
    atu_func_t f;
    logic [31:0] bn;
    logic [31:0] real_address_reg;
  } atu_row_t;
  // 4096-byte pages: three trailing zeros in the mask
  localparam logic [6:0] MSK = 7'h78;
  localparam logic [11:0] SG = 12'h003;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic kill_i = 1'b0;
  logic exec_req = 1'b0;
  logic ifu_req = 1'b0;
  atu_req_t exec_in = '0;
  atu_req_t ifu_in = '0;
  logic wdata_valid;
  logic port_busy;
  logic [3:0] busy_len = 4'h0;
  logic [3:0] wr_dly = 4'h0;
  logic mon = 1'b1;
  atu_sense_t sel = SEL_NONE;
  logic [63:0] prog_addr = 64'h0123_4567_89ab_cdef;
  logic exec_ack_o, ifu_ack_o, busy_o, done_o, rma_full_o;
  logic locked_o, miss_o, multi_hit_o, val_fault_o;
  logic [31:0] rma_o;
  logic [47:0] utp_o;
  logic [63:0] sense_o;
  int error_cnt = 0;
  int compares = 0;
  int mh_cnt = 0;
  atu_row_t rows [4] = '{
    '{F_XLATE, 32'h0004_5abc, 32'h0123_4abc},
    '{F_XLATE, 32'h0004_5000, 32'h0123_4000},
    '{F_XLATE, 32'h0004_5fff, 32'h0123_4fff},
    '{F_REAL, 32'h0007_1234, 32'h0007_1234}
  };

  atu_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .kill_i(kill_i),
    .exec_req_i(exec_req), .exec_in_i(exec_in), .ifu_req_i(ifu_req),
    .ifu_in_i(ifu_in), .wdata_valid_i(wdata_valid),
    .port_busy_i(port_busy), .monitor_mode_i(mon),
    .sense_sel_i(sel), .sense_idx_i(6'h00), .prog_addr_i(prog_addr),
    .exec_ack_o(exec_ack_o), .ifu_ack_o(ifu_ack_o), .busy_o(busy_o),
    .done_o(done_o), .rma_full_o(rma_full_o), .rma_o(rma_o),
    .utp_o(utp_o), .locked_o(locked_o), .miss_o(miss_o),
    .val_fault_o(val_fault_o), .multi_hit_o(multi_hit_o), .corr_err_o(),
    .val_par_err_o(), .sense_o(sense_o));

  atu_far_end far (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .rma_full_i(rma_full_o), .exec_ack_i(exec_ack_o),
    .func_i(exec_in.func), .busy_len_i(busy_len), .wr_dly_i(wr_dly),
    .port_busy_o(port_busy), .wdata_valid_o(wdata_valid));

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  // multi-hit is a one-cycle pulse in mid-function, so count it here
  always @(negedge mclk_i) begin
    if (multi_hit_o === 1'b1) mh_cnt++;
  end

  task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // exec request held until ack, then wait up to maxw for done
  task automatic op(input atu_func_t f, input logic [31:0] bn,
                    input logic [31:0] dat, input int maxw,
                    output int aw, output int cyc);
    exec_in.func = f;
    exec_in.ring = 4'h1;
    exec_in.space_index = (f == F_LD_REAL || f == F_LD_VALID) ? 12'h000 : SG;
    exec_in.bn = bn;
    exec_in.mask_copy = MSK;
    exec_in.data = dat;
    exec_req = 1'b1;
    aw = 0;
    cyc = 0;
    do begin
      @(negedge mclk_i);
      aw++;
    end while (exec_ack_o !== 1'b1 && aw < 40);
    exec_req = 1'b0;
    while (done_o !== 1'b1 && cyc < maxw) begin
      @(negedge mclk_i);
      cyc++;
    end
    if (done_o !== 1'b1) cyc = -1;
  endtask

  // page 0x45 of space 3 onto frame 0x1234, readable, any ring
  task automatic load_page(input logic [2:0] ctl);
    int aw;
    int cyc;
    op(F_LD_ASSOC, 32'h0004_5fff, {29'h0, ctl}, 8, aw, cyc);
    chk_n(cyc, 2);
    op(F_LD_REAL, 32'h0123_4fff, 32'h0123_4fff, 8, aw, cyc);
    chk_n(cyc, 2);
    op(F_LD_VALID, 32'h0000_050f, 32'h0000_050f, 8, aw, cyc);
    chk_n(cyc, 2);
  endtask

  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    int aw;
    int cyc;
    logic [31:0] keep;
    repeat (10) @(negedge mclk_i);
    chk_v(64'({busy_o, locked_o, rma_full_o, rma_o}), 64'h0);
    sys_rst_i = 1'b0;
    @(negedge mclk_i);
    chk_v(sense_o, prog_addr);
    op(F_LD_PSM, 32'h0, 32'hffff_f000, 8, aw, cyc);
    chk_n(cyc, 2);
    sel = SEL_PSM;
    @(negedge mclk_i);
    chk_v(sense_o, 64'(MSK));
    sel = SEL_NONE;
    load_page(3'h7);
    foreach (rows[i]) begin
      op(rows[i].f, rows[i].bn, 32'h0, 8, aw, cyc);
      chk_n(cyc, 2);
      chk_v(64'(rma_o), 64'(rows[i].real_address_reg));
      chk_v(64'(utp_o), 64'({4'h1, SG, rows[i].bn}));
    end
    chk_n(mh_cnt, 0);
    // simultaneous requests: exec first, fetch waits its turn
    ifu_in = exec_in;
    ifu_in.func = F_REAL;
    ifu_in.bn = 32'h0000_0bbb;
    exec_in.func = F_REAL;
    exec_in.bn = 32'h0000_0aaa;
    exec_req = 1'b1;
    ifu_req = 1'b1;
    @(negedge mclk_i);
    chk_v(64'({exec_ack_o, ifu_ack_o}), 64'h2);
    exec_req = 1'b0;
    cyc = 0;
    while (ifu_ack_o !== 1'b1 && cyc < 20) begin
      @(negedge mclk_i);
      cyc++;
    end
    ifu_req = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk_v(64'(utp_o[31:0]), 64'h0bbb);
    // storage rank refuses: second function must wait it out
    busy_len = 4'h6;
    op(F_XLATE, 32'h0004_5111, 32'h0, 8, aw, cyc);
    op(F_XLATE, 32'h0004_5222, 32'h0, 20, aw, cyc);
    chk_v(64'(cyc > 2), 64'h1);
    chk_v(64'(rma_o), 64'h0123_4222);
    busy_len = 4'h0;
    repeat (8) @(negedge mclk_i);
    // write with no data hangs until killed
    op(F_XLATE_WR, 32'h0004_5333, 32'h0, 10, aw, cyc);
    chk_n(cyc, -1);
    chk_v(64'(busy_o), 64'h1);
    kill_i = 1'b1;
    @(negedge mclk_i);
    kill_i = 1'b0;
    @(negedge mclk_i);
    chk_v(64'({busy_o, done_o}), 64'h0);
    wr_dly = 4'h4;
    op(F_XLATE_WR, 32'h0004_5333, 32'h0, 20, aw, cyc);
    chk_v(64'(cyc > 2), 64'h1);
    chk_v(64'(rma_o), 64'h0123_4333);
    // same page in a second way gives two hits
    load_page(3'h5);
    op(F_XLATE, 32'h0004_5abc, 32'h0, 8, aw, cyc);
    chk_n(mh_cnt, 1);
    // job mode: the second copy lacks its job-full bit, one hit only
    mon = 1'b0;
    op(F_XLATE, 32'h0004_5abc, 32'h0, 8, aw, cyc);
    chk_v(64'({miss_o, rma_o}), 64'h0123_4abc);
    chk_n(mh_cnt, 1);
    mon = 1'b1;
    op(F_PURGE_ALL, 32'h0, 32'h0, 40, aw, cyc);
    chk_n(cyc, 17);
    keep = rma_o;
    op(F_XLATE, 32'h0004_5abc, 32'h0, 8, aw, cyc);
    chk_v(64'({miss_o, locked_o, val_fault_o}), 64'h6);
    chk_v(64'(rma_o), 64'(keep));
    chk_v(64'(utp_o), 64'({4'h1, SG, 32'h0004_5abc}));
    // exec request waits out the lock timeout, then unlocks
    op(F_REAL, 32'h0000_0ccc, 32'h0, 8, aw, cyc);
    chk_v(64'(aw >= 5), 64'h1);
    chk_v(64'({locked_o, rma_o}), 64'h0ccc);
    op(F_XLATE, 32'h0004_5abc, 32'h0, 8, aw, cyc);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk_v(64'({locked_o, busy_o}), 64'h0);
    sys_rst_i = 1'b0;
    end_of_test();
  end
endmodule
